// >>> src/acdr_rx.sv
// oversampling receive front end: start qualification and per-bit voting
// How it works
// - mode field zero selects normal speed, one selects double speed
// - sixteen samples per bit in normal, eight in double speed
// - falling edge from idle starts detection; first low sample is sample one
// - start qualified on samples 8,9,10 normal or 4,5,6 double
// - two or more low samples accept start and lock bit timing
// - fewer than two low rejects start as noise; wait for new edge
// - each data and parity bit decided by majority of centre samples
// - repeat per-bit decision until whole configured payload recovered
// - only the first stop bit is sampled; further stop bits ignored
// - low majority on first stop bit sets frame error
// - both modes see next start right after stop vote samples
// - payload length is character size plus parity, five to ten bits
`timescale 1ns/1ps
`default_nettype none
module acdr_rx
   import acdr_pkg::*;
#(
   parameter int DATA_W = 10
)
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              rx_enable,
   input  wire logic              sample_tick,
   input  wire logic              rxd,
   input  wire logic [1:0]        receive_sampling_mode_field,
   input  wire logic [3:0]        payload_len,
   output logic [DATA_W-1:0]      rx_data,
   output logic                   rx_valid,
   output logic                   frame_error,
   output logic                   start_reject,
   output logic                   busy
);
   acdr_state_e       state_ff;
   acdr_state_e       nxt_state;
   logic [4:0]        cnt_ff;
   logic [4:0]        nxt_cnt;
   logic [3:0]        bit_ff;
   logic [3:0]        nxt_bit;
   logic [DATA_W-1:0] shift_ff;
   logic [DATA_W-1:0] nxt_shift;
   logic              prev_ff;
   logic              nxt_prev;
   logic [DATA_W-1:0] data_ff;
   logic [DATA_W-1:0] nxt_data;
   logic              valid_ff;
   logic              nxt_valid;
   logic              ferr_ff;
   logic              nxt_ferr;
   logic              rej_ff;
   logic              nxt_rej;
   logic              busy_ff;
   logic              nxt_busy;
   logic              dec_ff;
   logic              nxt_dec;

   logic              dbl;
   logic [4:0]        spb;
   logic [4:0]        first;
   logic [3:0]        len;
   logic              in_centre;
   logic              vote_done;
   logic              bit_end;
   logic              vote_clr;
   logic              vote_take;
   logic              vote_level;

   // mode decode; codes other than double speed fall back to normal
   assign dbl   = (receive_sampling_mode_field == ACDR_MODE_DOUBLE);
   assign spb   = dbl ? ACDR_SPB_DOUBLE : ACDR_SPB_NORMAL;
   assign first = dbl ? ACDR_FIRST_DOUBLE : ACDR_FIRST_NORMAL;

   // clamp payload to the legal five to ten bits
   always_comb begin
      len = payload_len;
      if (payload_len < ACDR_LEN_MIN) begin
         len = ACDR_LEN_MIN;
      end else if (payload_len > ACDR_LEN_MAX) begin
         len = ACDR_LEN_MAX;
      end
   end

   // sample positions within the current bit
   assign in_centre = sample_tick && (cnt_ff >= first) && (cnt_ff <= first + 5'h2);
   assign vote_done = sample_tick && (cnt_ff == first + 5'h2);
   assign bit_end   = sample_tick && (cnt_ff == spb);
   assign vote_take = in_centre && (state_ff != ACDR_IDLE);
   assign vote_clr  = (state_ff == ACDR_IDLE) || bit_end;

   acdr_vote u_vote (
      .core_clk (core_clk),
      .rst      (rst),
      .clr      (vote_clr),
      .take     (vote_take),
      .rxd      (rxd),
      .level    (vote_level)
   );

   // receive sequencer; the vote result is ready one clock after vote_done
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_bit   = bit_ff;
      nxt_shift = shift_ff;
      nxt_prev  = prev_ff;
      nxt_data  = data_ff;
      nxt_valid = 1'b0;
      nxt_ferr  = ferr_ff;
      nxt_rej   = 1'b0;
      nxt_busy  = busy_ff;
      // one-clock strobe after the third centre sample, so each bit is decided once
      nxt_dec   = vote_done;
      if (sample_tick) begin
         nxt_prev = rxd;
         nxt_cnt  = cnt_ff + 5'h1;
      end
      unique case (state_ff)
         ACDR_IDLE: begin
            nxt_busy = 1'b0;
            if (sample_tick && prev_ff && !rxd) begin
               nxt_state = ACDR_START;
               nxt_cnt   = 5'h2;
               nxt_busy  = 1'b1;
            end
         end
         ACDR_START: begin
            // decide one clock after the third centre sample
            if (dec_ff) begin
               if (!vote_level) begin
                  nxt_state = ACDR_DATA;
                  nxt_bit   = 4'h0;
               end else begin
                  nxt_state = ACDR_IDLE;
                  nxt_rej   = 1'b1;
                  nxt_busy  = 1'b0;
               end
            end
            if (bit_end) begin
               nxt_cnt = 5'h1;
            end
         end
         ACDR_DATA: begin
            if (dec_ff) begin
               // lsb first: shift in from the top, align at the end
               nxt_shift = {vote_level, shift_ff[DATA_W-1:1]};
               nxt_bit   = bit_ff + 4'h1;
            end
            if (bit_end) begin
               nxt_cnt = 5'h1;
               if (bit_ff == len) begin
                  nxt_state = ACDR_STOP;
               end
            end
         end
         ACDR_STOP: begin
            // only the first stop bit is voted; the rest is plain idle
            if (dec_ff) begin
               nxt_ferr  = !vote_level;
               nxt_valid = 1'b1;
               nxt_data  = shift_ff >> (4'(DATA_W) - len);
               // keep the real last sample: a low stop bit must not fake an edge
               nxt_state = ACDR_IDLE;
               nxt_busy  = 1'b0;
            end
         end
      endcase
      if (!rx_enable) begin
         nxt_state = ACDR_IDLE;
         nxt_busy  = 1'b0;
         nxt_valid = 1'b0;
         nxt_rej   = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ACDR_IDLE;
         cnt_ff   <= 5'h1;
         bit_ff   <= 4'h0;
         shift_ff <= '0;
         prev_ff  <= 1'b1;
         data_ff  <= '0;
         valid_ff <= 1'b0;
         ferr_ff  <= 1'b0;
         rej_ff   <= 1'b0;
         busy_ff  <= 1'b0;
         dec_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         bit_ff   <= nxt_bit;
         shift_ff <= nxt_shift;
         prev_ff  <= nxt_prev;
         data_ff  <= nxt_data;
         valid_ff <= nxt_valid;
         ferr_ff  <= nxt_ferr;
         rej_ff   <= nxt_rej;
         busy_ff  <= nxt_busy;
         dec_ff   <= nxt_dec;
      end
   end

   assign rx_data      = data_ff;
   assign rx_valid     = valid_ff;
   assign frame_error  = ferr_ff;
   assign start_reject = rej_ff;
   assign busy         = busy_ff;
endmodule
`default_nettype wire

// >>> src/acdr_pkg.sv
// constants and types shared by the receive clock and data recovery block
package acdr_pkg;
   // sampling mode field encodings
   localparam logic [1:0] ACDR_MODE_NORMAL = 2'h0;
   localparam logic [1:0] ACDR_MODE_DOUBLE = 2'h1;
   // samples per bit
   localparam logic [4:0] ACDR_SPB_NORMAL  = 5'h10;
   localparam logic [4:0] ACDR_SPB_DOUBLE  = 5'h08;
   // first of the three centre samples (second and third follow)
   localparam logic [4:0] ACDR_FIRST_NORMAL = 5'h08;
   localparam logic [4:0] ACDR_FIRST_DOUBLE = 5'h04;
   // payload length limits (character size plus parity)
   localparam logic [3:0] ACDR_LEN_MIN = 4'h5;
   localparam logic [3:0] ACDR_LEN_MAX = 4'ha;
   // receiver states
   typedef enum logic [1:0] {
      ACDR_IDLE  = 2'b00,
      ACDR_START = 2'b01,
      ACDR_DATA  = 2'b10,
      ACDR_STOP  = 2'b11
   } acdr_state_e;
endpackage

// >>> src/acdr_vote.sv
// three-sample majority voter collecting the centre samples of one bit
`timescale 1ns/1ps
`default_nettype none
module acdr_vote
   import acdr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clr,
   input  wire logic       take,
   input  wire logic       rxd,
   output logic            level
);
   logic [1:0] ones_ff;
   logic [1:0] nxt_ones;

   // count high samples; cleared at the start of each bit
   always_comb begin
      nxt_ones = ones_ff;
      if (clr) begin
         nxt_ones = 2'h0;
      end
      if (take && rxd) begin
         nxt_ones = (clr ? 2'h0 : ones_ff) + 2'h1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ones_ff <= 2'h0;
      end else begin
         ones_ff <= nxt_ones;
      end
   end

   // two or more high samples means the bit is high
   assign level = ones_ff[1];
endmodule
`default_nettype wire

// >>> dv/acdr_rx_sva.sv
// port checker for the receive front end
`timescale 1ns/1ps
`default_nettype none
module acdr_rx_sva #(parameter int DATA_W = 10) (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              rx_enable,
   input wire logic              sample_tick,
   input wire logic              rxd,
   input wire logic [1:0]        receive_sampling_mode_field,
   input wire logic [3:0]        payload_len,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic              rx_valid,
   input wire logic              frame_error,
   input wire logic              start_reject,
   input wire logic              busy
);
   logic line_ff;
   // line level at the last tick, idle high after reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) line_ff <= 1'b1;
      else if (sample_tick) line_ff <= rxd;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_edge; rx_enable && sample_tick && !rxd && line_ff && !busy; endsequence
   sequence s_rise; $rose(busy); endsequence
   property p_start;  s_edge |=> busy; endproperty
   property p_tick;   s_rise |-> $past(sample_tick); endproperty
   property p_vpulse; rx_valid |=> !rx_valid; endproperty
   property p_rpulse; start_reject |=> !start_reject; endproperty
   // results change only at the character strobe
   property p_hold;   !rx_valid |-> $stable(frame_error) && $stable(rx_data); endproperty
   property p_vbusy;  rx_valid |-> !busy && $past(busy, 2); endproperty
   property p_vtick;  rx_valid |-> $past(sample_tick, 2); endproperty
   property p_bound;  s_rise |-> ##[1:1000] !busy; endproperty
   a_start:  assert property (p_start) else $error("no busy after start edge");
   a_tick:   assert property (p_tick) else $error("busy rose without tick");
   a_vpulse: assert property (p_vpulse) else $error("rx_valid too long");
   a_rpulse: assert property (p_rpulse) else $error("start_reject too long");
   a_hold:   assert property (p_hold) else $error("result moved without rx_valid");
   a_vbusy:  assert property (p_vbusy) else $error("rx_valid outside frame end");
   a_vtick:  assert property (p_vtick) else $error("rx_valid latency off");
   a_bound:  assert property (p_bound) else $error("frame never ended");
endmodule
bind acdr_rx acdr_rx_sva #(.DATA_W(DATA_W)) i_acdr_rx_sva (.*);
`default_nettype wire

// >>> dv/acdr_tx_model.sv
// remote sender: one line level per bit, spb ticks each
`timescale 1ns/1ps
`default_nettype none
module acdr_tx_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        sample_tick,
   input  wire logic        go,
   input  wire logic [11:0] frame,
   input  wire logic [3:0]  nbits,
   input  wire logic [4:0]  spb,
   output var  logic        rxd,
   output var  logic        busy
);
   logic [4:0] smp;
   logic [3:0] bit_i;
   // shares the receiver tick, so rate error is zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
         rxd <= 1'b1;
         smp <= 5'h00;
         bit_i <= 4'h0;
      end else if (go) begin
         // line back to idle first, so a low stop bit cannot hide the next start edge
         rxd <= 1'b1;
         busy <= 1'b1;
         smp <= 5'h00;
         bit_i <= 4'h0;
      end else if (sample_tick) begin
         rxd <= busy ? frame[bit_i] : 1'b1; // idle high once the frame ends; the stop bit itself comes from frame and may be low
         if (busy && smp == spb - 5'h01) begin
            smp <= 5'h00;
            bit_i <= bit_i + 4'h1;
            if (bit_i == nbits - 4'h1) busy <= 1'b0;
         end else if (busy) smp <= smp + 5'h01;
      end
   end
endmodule
`default_nettype wire

// >>> dv/async_rx_clock_data_recovery_tb_top.sv
// random and corner frames through the receive front end
`timescale 1ns/1ps
`default_nettype none
module async_rx_clock_data_recovery_tb_top;
   import acdr_pkg::*;
   logic core_clk, rst, rx_enable, rxd, go, tx_busy, rx_valid, frame_error, start_reject, busy;
   logic        sample_tick = 1'b0;
   logic [1:0]  tdiv = 2'h0;
   logic [1:0]  mode;
   logic [3:0]  len, nbits;
   logic [4:0]  spb;
   logic [11:0] frame;
   logic [9:0]  rx_data;
   logic [15:0] rnd;
   int          err_count, cmp_count, tn, cyc;
   acdr_rx i_acdr_rx (.core_clk(core_clk), .rst(rst), .rx_enable(rx_enable), .sample_tick(sample_tick),
      .rxd(rxd), .receive_sampling_mode_field(mode), .payload_len(len), .rx_data(rx_data),
      .rx_valid(rx_valid), .frame_error(frame_error), .start_reject(start_reject), .busy(busy));
   acdr_tx_model i_acdr_tx_model (.core_clk(core_clk), .rst(rst), .sample_tick(sample_tick), .go(go),
      .frame(frame), .nbits(nbits), .spb(spb), .rxd(rxd), .busy(tx_busy));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // tick every third clock keeps ticks apart
   always @(posedge core_clk) begin
      tdiv <= tdiv == 2'h2 ? 2'h0 : tdiv + 2'h1;
      sample_tick <= tdiv == 2'h0;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         test_done();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [9:0] msk(input logic [3:0] l);
      msk = 10'h3ff >> (4'ha - l);
   endfunction
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // gs nonzero sends a lone low pulse of gs samples instead of a frame
   task automatic run(input logic [1:0] m, input logic [3:0] l, input logic [9:0] d, input logic sb,
                      input logic [4:0] gs);
      int n;
      logic sv, sr, acc;
      n = 0;
      sv = 0;
      sr = 0;
      acc = gs == 5'h00 || gs > (m == ACDR_MODE_DOUBLE ? ACDR_FIRST_DOUBLE : ACDR_FIRST_NORMAL);
      @(posedge core_clk);
      mode <= m;
      len <= l;
      spb <= gs != 5'h00 ? gs : (m == ACDR_MODE_DOUBLE ? ACDR_SPB_DOUBLE : ACDR_SPB_NORMAL);
      nbits <= gs != 5'h00 ? 4'h1 : l + 4'h2;
      frame <= gs != 5'h00 ? 12'h000 : (12'(d & msk(l)) << 1) | (12'(sb) << (l + 4'h1));
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      while (n < 1500 && (n < 4 || tx_busy || busy)) begin
         @(posedge core_clk);
         #1;
         n++;
         if (start_reject === 1'b1) sr = 1;
         if (rx_valid === 1'b1) begin
            sv = 1;
            chk("rx_data", (gs != 5'h00 ? 10'h3ff : d) & msk(l), rx_data & msk(l));
            chk("frame_error", 10'(gs == 5'h00 && !sb), 10'(frame_error));
         end
      end
      chk("accepted", 10'(acc), 10'(sv));
      chk("rejected", 10'(!acc), 10'(sr));
      $display("test %0d done", tn++);
   endtask
   initial begin
      {rst, rx_enable, go, mode, len, nbits, spb, frame} = {3'b100, 2'h0, 4'h8, 4'h1, 5'h10, 12'h000};
      {err_count, cmp_count, tn, cyc} = 0;
      rnd = 16'h6a89;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      rx_enable <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         run(2'(m), 4'h5, 10'h015, 1'b1, 5'h00);
         run(2'(m), 4'ha, 10'h2c9, 1'b0, 5'h00);
         run(2'(m), 4'h8, 10'h000, 1'b1, 5'h03);
         run(2'(m), 4'h8, 10'h000, 1'b1, m ? 5'h05 : 5'h09);
      end
      repeat (24) begin
         rnd = lfsr(rnd);
         run(rnd[1:0], 4'h5 + 4'(rnd[3:1] % 3'h6), rnd[15:6], rnd[4] | rnd[5], 5'h00);
      end
      test_done();
   end
endmodule
`default_nettype wire
